// ==== logic/tw_consts.vh ====
`ifndef TW_CONSTS_VH
`define TW_CONSTS_VH

// System clock rate in kHz
`define TW_CLK_KHZ   50000
// Bus rates in kbit/s
`define TW_STD_KBPS  100
`define TW_FAST_KBPS 400
// One bus bit is four quarter phases; longest time rounds down
`define TW_QTR_STD   (`TW_CLK_KHZ / (4 * `TW_STD_KBPS))
`define TW_QTR_FAST  (`TW_CLK_KHZ / (4 * `TW_FAST_KBPS))
// Data bits per byte slot, ack not included
`define TW_SLOT_BITS 8
// Direction bit position in the address byte
`define TW_DIR_BIT   0

`endif

// ==== logic/tw_engine.v ====
// Operation
// RQ1: Bus is idle when both data and clock lines read high.
// RQ2: Byte slot is nine clocks: eight data bits MSB first, then ack.
// RQ3: Master signals end or error of a byte; slave signals data in or request.
// RQ4: A receiver may hold clock low; transmitter waits until released.
// RQ5: Start is data falling while clock is high.
// RQ6: Stop is data rising while clock is high.
// RQ7: Bus busy after a start, free after a stop.
// RQ8: First byte holds seven-bit address then direction bit.
// RQ9: Direction zero writes to slave, one reads from slave.
// RQ10: Master may issue repeated start without a stop.
// RQ11: Only the master ends a transfer, always with a stop.
// RQ12: Data changes only while clock is low.
// RQ13: Master clocks ack slot; transmitter releases data during it.
// RQ14: Receiver acks by holding data low through the ack clock.
// RQ15: Unaccepted address leaves data high; master stops and abandons.
// RQ16: Master receiver acks all bytes except the last.
// RQ17: Slave transmitter releases data after a missing ack.
// RQ18: Master starts only on an idle bus.
// RQ19: Master seeing low while sending high withdraws until bus idle.
// RQ20: Arbitration runs bit by bit over address then data.
// RQ21: Master and slave work at the same time, both directions.
// RQ22: Standard and fast bus rates are supported.
// RQ23: Lines only pulled low or released, sampled, synced, compared.
`include "tw_consts.vh"
`default_nettype none

module tw_engine
(
  input  wire       clock,
  input  wire       arst_n,
  input  wire       sclIn,
  input  wire       sdaIn,
  output reg        sclOut,
  output reg        sclOe,
  output reg        sdaOut,
  output reg        sdaOe,
  input  wire       fastMode,
  input  wire       cmdValid,
  input  wire       cmdStart,
  input  wire       cmdStop,
  input  wire       cmdRead,
  input  wire       cmdLast,
  input  wire [7:0] cmdByte,
  output reg        cmdReady,
  output reg        mDone,
  output reg        mNack,
  output reg        mArbLost,
  output reg  [7:0] mRxData,
  output reg        busBusy,
  input  wire       sEnable,
  input  wire [6:0] ownAddr,
  output reg        sRxValid,
  output reg  [7:0] sRxData,
  output reg        sTxReq,
  input  wire       sTxValid,
  input  wire [7:0] sTxData,
  output reg        sReadDir
);

  localparam [4:0] M_IDLE = 5'h01;
  localparam [4:0] M_STRT = 5'h02;
  localparam [4:0] M_BIT  = 5'h04;
  localparam [4:0] M_HOLD = 5'h08;
  localparam [4:0] M_STOP = 5'h10;

  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_RECV = 6'h02;
  localparam [5:0] S_ACK  = 6'h04;
  localparam [5:0] S_REQ  = 6'h08;
  localparam [5:0] S_SEND = 6'h10;
  localparam [5:0] S_TACK = 6'h20;

  localparam integer QTR_STD_LAST  = `TW_QTR_STD - 1;
  localparam integer QTR_FAST_LAST = `TW_QTR_FAST - 1;

  function [7:0] qtrLoad;
    input fast;
    begin
      qtrLoad = fast ? QTR_FAST_LAST[7:0] : QTR_STD_LAST[7:0]; // RQ22
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Line sampling and bus conditions
  reg sclM_q, sclS_q, sclP_q;
  reg sdaM_q, sdaS_q, sdaP_q;

  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sclM_q <= 1'b1;
      sclS_q <= 1'b1;
      sclP_q <= 1'b1;
      sdaM_q <= 1'b1;
      sdaS_q <= 1'b1;
      sdaP_q <= 1'b1;
    end
    else
    begin
      sclM_q <= sclIn; // RQ23
      sclS_q <= sclM_q;
      sclP_q <= sclS_q;
      sdaM_q <= sdaIn;
      sdaS_q <= sdaM_q;
      sdaP_q <= sdaS_q;
    end
  end

  wire startSeen = sclS_q & sclP_q & sdaP_q & ~sdaS_q; // RQ5
  wire stopSeen  = sclS_q & sclP_q & ~sdaP_q & sdaS_q; // RQ6
  wire sclRise   = sclS_q & ~sclP_q;
  wire sclFall   = ~sclS_q & sclP_q;
  wire busIdle   = ~busBusy & sclS_q & sdaS_q; // RQ1

  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      busBusy <= 1'b0;
    else if (startSeen)
      busBusy <= 1'b1; // RQ7
    else if (stopSeen)
      busBusy <= 1'b0; // RQ7
  end

  ////////////////////////////////////////////////////////////////////////
  // Master
  reg [4:0] mSt_q;
  reg [1:0] mPh_q;
  reg [7:0] qCnt_q;
  reg [3:0] mBit_q;
  reg [7:0] mSh_q;
  reg       mTx_q, mLast_q, mStop_q, mSdaLow_q, mSclLow_q, mErr_q;

  // Phase 2 waits for the clock to read high, so stretching holds us
  wire waitHigh = (mPh_q == 2'd2) & ~sclS_q & (mSt_q != M_HOLD); // RQ4
  wire adv      = (qCnt_q == 8'h00) & ~waitHigh;
  wire take     = cmdValid & cmdReady;

  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mSt_q     <= M_IDLE;
      mPh_q     <= 2'd0;
      qCnt_q    <= 8'h00;
      mBit_q    <= 4'h0;
      mSh_q     <= 8'hFF;
      mTx_q     <= 1'b0;
      mLast_q   <= 1'b0;
      mStop_q   <= 1'b0;
      mErr_q    <= 1'b0;
      mSdaLow_q <= 1'b0;
      mSclLow_q <= 1'b0;
      cmdReady  <= 1'b0;
      mDone     <= 1'b0;
      mNack     <= 1'b0;
      mArbLost  <= 1'b0;
      mRxData   <= 8'h00;
    end
    else
    begin
      mDone  <= 1'b0;
      qCnt_q <= (qCnt_q == 8'h00 || waitHigh) ? qtrLoad(fastMode)
                                              : qCnt_q - 8'h01;
      if (adv)
        mPh_q <= mPh_q + 2'd1;
      case (mSt_q)
        M_IDLE:
        begin
          cmdReady <= busIdle & ~take; // RQ18
          mPh_q    <= 2'd0;
          if (take & cmdStart & busIdle)
          begin
            mSt_q <= M_STRT;
            mTx_q <= 1'b1;
          end
        end
        M_HOLD:
        begin
          cmdReady <= ~take;
          mPh_q    <= 2'd0;
          if (take)
          begin
            mSt_q  <= cmdStart ? M_STRT : M_BIT; // RQ10
            mTx_q  <= cmdStart | ~cmdRead; // RQ9
            mBit_q <= 4'h0;
          end
        end
        M_STRT:
        begin
          if (adv)
          begin
            case (mPh_q)
              2'd0: mSdaLow_q <= 1'b0;
              2'd1: mSclLow_q <= 1'b0;
              2'd2: mSdaLow_q <= 1'b1; // RQ5
              default:
              begin
                mSclLow_q <= 1'b1;
                mSt_q     <= M_BIT;
                mBit_q    <= 4'h0;
              end
            endcase
          end
        end
        M_BIT:
        begin
          if (adv)
          begin
            case (mPh_q)
              2'd0:
                if (mBit_q == `TW_SLOT_BITS)
                  mSdaLow_q <= ~mTx_q & ~mLast_q; // RQ13 RQ14 RQ16
                else
                  mSdaLow_q <= ~mSh_q[7]; // RQ2 RQ12
              2'd1: mSclLow_q <= 1'b0;
              2'd2: mSclLow_q <= 1'b0;
              default:
              begin
                mSclLow_q <= 1'b1;
                mBit_q    <= mBit_q + 4'h1;
                if (mBit_q != `TW_SLOT_BITS)
                  mSh_q <= {mSh_q[6:0], sdaS_q};
                if (mBit_q != `TW_SLOT_BITS && mTx_q && mSh_q[7]
                    && !sdaS_q)
                begin
                  mSt_q     <= M_IDLE; // RQ19 RQ20
                  mSdaLow_q <= 1'b0;
                  mSclLow_q <= 1'b0;
                  mArbLost  <= 1'b1;
                  mNack     <= 1'b0;
                  mDone     <= 1'b1; // RQ3
                end
                else if (mBit_q == `TW_SLOT_BITS)
                begin
                  mRxData  <= mSh_q;
                  mArbLost <= 1'b0;
                  mErr_q   <= mTx_q & sdaS_q;
                  if ((mTx_q && sdaS_q) || mStop_q)
                    mSt_q <= M_STOP; // RQ11 RQ15
                  else
                  begin
                    mSt_q <= M_HOLD;
                    mNack <= 1'b0;
                    mDone <= 1'b1; // RQ3
                  end
                end
              end
            endcase
          end
        end
        M_STOP:
        begin
          if (adv)
          begin
            case (mPh_q)
              2'd0: mSdaLow_q <= 1'b1;
              2'd1: mSclLow_q <= 1'b0;
              2'd2: mSdaLow_q <= 1'b0; // RQ6
              default:
              begin
                mSt_q <= M_IDLE;
                mNack <= mErr_q; // RQ3
                mDone <= 1'b1;
              end
            endcase
          end
        end
        default: mSt_q <= M_IDLE;
      endcase
      if (take && (mSt_q == M_IDLE || mSt_q == M_HOLD))
      begin
        mSh_q   <= (cmdRead & ~cmdStart) ? 8'hFF : cmdByte; // RQ8
        mLast_q <= cmdLast;
        mStop_q <= cmdStop;
        mPh_q   <= 2'd0;
        qCnt_q  <= qtrLoad(fastMode);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Slave, runs beside the master on the same lines
  reg [5:0] sSt_q;
  reg [3:0] sBit_q;
  reg [7:0] sSh_q;
  reg       sAddrPh_q, sSdaLow_q, sSclLow_q;

  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sSt_q     <= S_IDLE;
      sBit_q    <= 4'h0;
      sSh_q     <= 8'h00;
      sAddrPh_q <= 1'b0;
      sSdaLow_q <= 1'b0;
      sSclLow_q <= 1'b0;
      sRxValid  <= 1'b0;
      sRxData   <= 8'h00;
      sTxReq    <= 1'b0;
      sReadDir  <= 1'b0;
    end
    else
    begin
      sRxValid <= 1'b0;
      sTxReq   <= 1'b0;
      if (startSeen)
      begin
        sSt_q     <= sEnable ? S_RECV : S_IDLE; // RQ21
        sBit_q    <= 4'h0;
        sAddrPh_q <= 1'b1;
        sSdaLow_q <= 1'b0;
        sSclLow_q <= 1'b0;
      end
      else if (stopSeen)
      begin
        sSt_q     <= S_IDLE;
        sSdaLow_q <= 1'b0;
        sSclLow_q <= 1'b0;
      end
      else
      begin
        case (sSt_q)
          S_IDLE: sSdaLow_q <= 1'b0;
          S_RECV:
          begin
            if (sclRise)
            begin
              sSh_q  <= {sSh_q[6:0], sdaS_q}; // RQ2
              sBit_q <= sBit_q + 4'h1;
            end
            else if (sclFall && sBit_q == `TW_SLOT_BITS)
            begin
              if (!sAddrPh_q)
              begin
                sRxData   <= sSh_q;
                sRxValid  <= 1'b1; // RQ3
                sSdaLow_q <= 1'b1; // RQ14
                sSt_q     <= S_ACK;
              end
              else if (sSh_q[7:1] == ownAddr) // RQ8
              begin
                sReadDir  <= sSh_q[`TW_DIR_BIT]; // RQ9
                sSdaLow_q <= 1'b1;
                sSt_q     <= S_ACK;
              end
              else
                sSt_q <= S_IDLE; // RQ15
              sAddrPh_q <= 1'b0;
            end
          end
          S_ACK:
          begin
            if (sclFall)
            begin
              sSdaLow_q <= 1'b0;
              sBit_q    <= 4'h0;
              if (sReadDir)
              begin
                sSt_q     <= S_REQ;
                sSclLow_q <= 1'b1; // RQ4
                sTxReq    <= 1'b1; // RQ3
              end
              else
                sSt_q <= S_RECV;
            end
          end
          S_REQ:
          begin
            if (sTxValid)
            begin
              sSh_q     <= sTxData;
              sSdaLow_q <= ~sTxData[7]; // RQ12
              sBit_q    <= 4'h0;
              sSt_q     <= S_SEND;
            end
          end
          S_SEND:
          begin
            // Clock is let go one cycle after data settles, never together
            sSclLow_q <= 1'b0; // RQ12
            if (sclFall)
            begin
              sBit_q <= sBit_q + 4'h1;
              sSh_q  <= {sSh_q[6:0], 1'b1};
              if (sBit_q == 4'h7)
              begin
                sSdaLow_q <= 1'b0; // RQ13
                sSt_q     <= S_TACK;
              end
              else
                sSdaLow_q <= ~sSh_q[6];
            end
          end
          S_TACK:
          begin
            if (sclRise && sdaS_q)
              sSt_q <= S_IDLE; // RQ17
            else if (sclFall)
            begin
              sSt_q     <= S_REQ;
              sSclLow_q <= 1'b1;
              sTxReq    <= 1'b1;
            end
          end
          default: sSt_q <= S_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Open-drain pins: driven value is always low
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
      sclOe  <= 1'b0;
      sdaOe  <= 1'b0;
    end
    else
    begin
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
      sclOe  <= mSclLow_q | sSclLow_q; // RQ23
      sdaOe  <= mSdaLow_q | sSdaLow_q; // RQ23
    end
  end

endmodule

`default_nettype wire

// ==== test/tw_engine_asserts.sv ====
`default_nettype none
module tw_engine_chk
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sclOut,
  input wire logic sclOe,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic cmdReady,
  input wire logic mDone,
  input wire logic mNack,
  input wire logic mArbLost,
  input wire logic busBusy,
  input wire logic sTxReq
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  chk_open_drain: assert property (!sclOut && !sdaOut)
    else $error("line driven high");
  chk_busy_start: assert property (
    $fell(sdaIn) && sclIn && $past(sclIn) |-> ##[1:6] busBusy)
    else $error("start not seen");
  chk_free_stop: assert property (
    $rose(sdaIn) && sclIn && $past(sclIn) |-> ##[1:6] !busBusy)
    else $error("stop not seen");
  chk_idle_start: assert property (
    cmdReady && !sclOe |-> !busBusy)
    else $error("ready on busy bus");
  chk_arb_off: assert property (
    mDone && mArbLost |-> (!sdaOe && !sclOe) [*8])
    else $error("bus kept after loss");
  chk_nack_stop: assert property (
    mDone && mNack |-> ##[0:6] !busBusy)
    else $error("no stop after nack");
  chk_done_pulse: assert property (mDone |=> !mDone)
    else $error("done too long");
  chk_tx_stretch: assert property (sTxReq |=> sclOe)
    else $error("clock not held");
  cover property (mDone && mNack);
  cover property (mDone && mArbLost);
  cover property (sTxReq);
endmodule
////////////////////////////////////////////////////////////
bind tw_engine tw_engine_chk chk
(
  .clock(clock), .arst_n(arst_n), .sclIn(sclIn), .sdaIn(sdaIn),
  .sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .cmdReady(cmdReady), .mDone(mDone), .mNack(mNack),
  .mArbLost(mArbLost), .busBusy(busBusy), .sTxReq(sTxReq)
);
`default_nettype wire

// ==== test/tw_peer.sv ====
`default_nettype none
module tw_peer
#(
  parameter logic [6:0] ADDR = 7'h2A
)
(
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [7:0] txByte,
  output var  logic       sdaPull = 0,
  output var  logic       sclPull = 0,
  output var  logic [7:0] rxByte = 8'h00
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh;
  logic [7:0] tx;
  int         n = 0;
  logic       sel = 0;
  logic       rd = 0;
  logic       first = 0;
  always @(negedge sda)
    if (scl)
    begin
      n = 0;
      first = 1;
      sdaPull = 0;
    end
  always @(posedge sda)
    if (scl)
      sel = 0;
  always @(posedge scl)
  begin
    n = n + 1;
    if (n <= 8)
      sh = {sh[6:0], sda};
    else if (rd && sda)
      sel = 0;
  end
  always @(negedge scl)
    if (n == 8 && first)
    begin
      first = 0;
      sel = (sh[7:1] == ADDR);
      rd = sh[0];
      sdaPull = sel;
    end
    else if (n == 8 && sel)
    begin
      if (!rd)
        rxByte = sh;
      sdaPull = !rd;
    end
    else if (n == 9)
    begin
      n = 0;
      tx = txByte;
      sdaPull = sel && rd && !tx[7];
      if (sel && rd)
      begin
        // Slow answer so the master has to wait out the stretch
        sclPull = 1;
        #6000 sclPull = 0;
      end
    end
    else if (sel && rd && n < 8)
      sdaPull = !tx[7 - n];
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic       f;
    logic [7:0] a;
    logic       p;
    logic       r;
    logic [7:0] d;
    logic       nk;
  } tw_row_t;
  // Fast, address byte, stop, read, data, refused; row 1 is a restart
  tw_row_t rows [4] = '{'{0, 8'h54, 0, 0, 8'hA5, 0},
    '{0, 8'h55, 1, 1, 8'h3C, 0}, '{1, 8'h2A, 0, 0, 8'h00, 1},
    '{1, 8'h54, 1, 0, 8'h81, 0}};
  logic       clock, arst_n, fastMode, cmdValid, cmdStart, cmdStop;
  logic       cmdRead, cmdLast, sEnable, sTxValid, tbScl, tbSda;
  logic       sclOe, sdaOe, cmdReady, mDone, mNack, mArbLost, busBusy;
  logic       sRxValid, sTxReq, sReadDir, pScl, pSda;
  logic [7:0] cmdByte, sTxData, pTx, pRx, mRxData, sRxData;
  logic [6:0] ownAddr;
  logic [8:0] rx;
  int         errorCnt = 0, checksDone = 0, i;
  int         rxPulses = 0;
  wire logic  sclW = !(sclOe | pScl | tbScl);
  wire logic  sdaW = !(sdaOe | pSda | tbSda);
  tw_engine uut
  (
    .clock(clock), .arst_n(arst_n), .sclIn(sclW), .sdaIn(sdaW),
    .sclOut(), .sclOe(sclOe), .sdaOut(), .sdaOe(sdaOe),
    .fastMode(fastMode), .cmdValid(cmdValid), .cmdStart(cmdStart),
    .cmdStop(cmdStop), .cmdRead(cmdRead), .cmdLast(cmdLast),
    .cmdByte(cmdByte), .cmdReady(cmdReady), .mDone(mDone),
    .mNack(mNack), .mArbLost(mArbLost), .mRxData(mRxData),
    .busBusy(busBusy), .sEnable(sEnable), .ownAddr(ownAddr),
    .sRxValid(sRxValid), .sRxData(sRxData), .sTxReq(sTxReq),
    .sTxValid(sTxValid), .sTxData(sTxData), .sReadDir(sReadDir)
  );
  tw_peer peer
  (
    .scl(sclW), .sda(sdaW), .txByte(pTx), .sdaPull(pSda),
    .sclPull(pScl), .rxByte(pRx)
  );
  initial
  begin
    clock = 0;
    forever #10 clock = !clock;
  end
  always @(posedge clock)
    sTxValid <= sTxReq;
  always @(posedge clock)
    if (sRxValid === 1'b1)
      rxPulses <= rxPulses + 1;
  ////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    checksDone++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      errorCnt++;
    end
  endtask
  task automatic step(int n);
    repeat (n) @(posedge clock);
    #2;
  endtask
  task automatic bound(int k, int lim);
    if (k >= lim)
    begin
      $display("ERROR wait expected done seen timeout");
      errorCnt++;
      conclude();
    end
  endtask
  task automatic mcmd(logic s, p, r, l, logic [7:0] b);
    int k;
    for (k = 0; k < 200 && cmdReady !== 1'b1; k++)
      step(1);
    bound(k, 200);
    {cmdStart, cmdStop, cmdRead, cmdLast, cmdByte} = {s, p, r, l, b};
    cmdValid = 1;
    step(1);
    cmdValid = 0;
    for (k = 0; k < 30000 && mDone !== 1'b1; k++)
      step(1);
    bound(k, 30000);
  endtask
  // Bus master at a 160 ns bit; waits while anyone stretches the clock
  task automatic tbyte(logic [8:0] b, output logic [8:0] r);
    int k;
    for (int n = 8; n >= 0; n--)
    begin
      tbSda = !b[n];
      #80 tbScl = 0;
      for (k = 0; k < 99 && sclW !== 1'b1; k++)
        #20;
      bound(k, 99);
      #20 r[n] = sdaW;
      #20 tbScl = 1;
      #40;
    end
  endtask
  task automatic tcond(logic s);
    tbSda = !s;
    #80 tbScl = 0;
    #80 tbSda = s;
    #80 tbScl = s;
    #40;
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", checksDone, errorCnt);
    if (errorCnt == 0 && checksDone > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    {arst_n, fastMode, cmdValid, cmdStart, cmdStop, cmdRead} = '0;
    {cmdLast, cmdByte, sTxData, pTx, tbScl, tbSda, sTxValid} = '0;
    sEnable = 1;
    ownAddr = 7'h33;
    step(5);
    chk("resetOut", 0, {sclOe, sdaOe, cmdReady, mDone});
    arst_n = 1;
    foreach (rows[k])
    begin
      fastMode = rows[k].f;
      pTx = rows[k].d;
      mcmd(1, 0, 0, 0, rows[k].a);
      chk("addrNack", rows[k].nk, mNack);
      if (!rows[k].nk)
      begin
        mcmd(0, rows[k].p, rows[k].r, rows[k].r, rows[k].d);
        chk("data", rows[k].d, rows[k].r ? mRxData : pRx);
      end
      step(6);
      chk("busBusy", !(rows[k].p | rows[k].nk), busBusy);
    end
    fork
      mcmd(1, 1, 0, 0, 8'hFE);
      begin
        for (i = 0; i < 3000 && sclOe !== 1'b1; i++)
          step(1);
        tbSda = 1;
      end
    join
    chk("arbLost", 1, mArbLost);
    step(2);
    chk("refused", 0, cmdReady);
    tbSda = 0;
    step(6);
    chk("freed", 0, busBusy);
    sTxData = 8'h5A;
    tcond(1);
    tbyte({8'h66, 1'b1}, rx);
    chk("slaveAck", 0, rx[0]);
    tbyte({8'hC3, 1'b1}, rx);
    chk("slaveRx", 8'hC3, sRxData);
    chk("rxPulses", 1, rxPulses);
    chk("slaveDir", 0, sReadDir);
    tcond(1);
    tbyte({8'h67, 1'b1}, rx);
    chk("slaveDir", 1, sReadDir);
    tbyte(9'h1FF, rx);
    chk("slaveTx", 8'h5A, rx[8:1]);
    tcond(0);
    tcond(1);
    tbyte({8'h68, 1'b1}, rx);
    chk("foreignAck", 1, rx[0]);
    tcond(0);
    step(6);
    chk("idle", 0, busBusy);
    conclude();
  end
endmodule
`default_nettype wire
